// [design/loopback_mgmt_pkg.sv]
// constants, types and state encodings for the loopback module management block
// Operation
// - Low power when power-class bits 7:4 are zero or the low-power pin is high.
// - No interrupt flag: solid green in low power, solid red in high power.
// - Any interrupt flag set: blink green in low power, red in high power.
// - Serial slave works at fast-mode rates from 0 up to 400 kHz.
// - Clock stretch by the device lasts under 100 us; master tolerates stretches.
// - Address 0 returns a fixed form-factor identification code.
// - Address 3 returns module state pattern 0000_001x.
// - Address 86 returns host interface code 11h.
// - Address 87 returns media interface code BFh, passive loopback.
// - Address 88 returns lane count 80h: eight host lanes, zero media lanes.
// - Transmit lane n returns on receive lane n, polarity preserved.
// - Low-power pin high keeps low power; low lets power class decide.
// - Interrupt held while any latched flag set; cleared once the host reads flags.
package loopback_mgmt_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int CLK_KHZ = 100000;
   localparam int BLINK_HALF_MS = 500;
   localparam int BLINK_HALF_CYC_DEF = BLINK_HALF_MS * CLK_KHZ;
   localparam int BLINK_W = 26;
   localparam int MAX_STRETCH_US = 100;
   localparam int MAX_STRETCH_CYC_DEF = MAX_STRETCH_US * CLK_MHZ;
   localparam int STR_W = 8;
   localparam logic [STR_W-1:0] STRETCH_CYC_DEF = 8'h04;

   // ----------------------------------------------------------------
   // serial slave and register map
   // ----------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR = 7'h50;
   localparam logic [7:0] FORM_ID_ADDR = 8'h00;
   localparam logic [7:0] MOD_STATE_ADDR = 8'h03;
   localparam logic [7:0] FLAG_ADDR = 8'h09;
   localparam logic [7:0] TYPE_ADDR = 8'h55;
   localparam logic [7:0] HOST_IF_ADDR = 8'h56;
   localparam logic [7:0] MEDIA_IF_ADDR = 8'h57;
   localparam logic [7:0] LANE_CNT_ADDR = 8'h58;
   localparam logic [7:0] PWR_CLASS_ADDR = 8'hC8;
   localparam logic [7:0] MOD_STATE_VAL = 8'h02;
   localparam logic [7:0] TYPE_VAL = 8'h03;
   localparam logic [7:0] HOST_IF_VAL = 8'h11;
   localparam logic [7:0] MEDIA_IF_VAL = 8'hBF;
   localparam logic [7:0] LANE_CNT_VAL = 8'h80;
   localparam int PCLS_LSB = 5;
   localparam logic [2:0] PCLS_RESET = 3'h0;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int LANES = 8;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_ACK_A = 7'h04,
      ST_WR = 7'h08,
      ST_ACK_W = 7'h10,
      ST_RD = 7'h20,
      ST_ACK_R = 7'h40
   } slave_state_t;

   typedef struct packed {
      logic green;
      logic red;
   } led_t;

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [1:0] sel_s;
      logic [1:0] lp_s;
      logic [7:0] al_s1;
      logic [7:0] al_s2;
      slave_state_t st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic ptr_ok;
      logic nack;
      logic sda_oe;
      logic [STR_W-1:0] str_cnt;
      logic [7:0] flags;
      logic [2:0] pcls;
      logic [BLINK_W-1:0] blink_cnt;
      logic blink;
      logic int_n;
      logic pwr_hi;
      led_t led;
   } sys_state_t;

   typedef struct packed {
      logic [1:0] rst_s;
      logic [LANES-1:0] tx1;
      logic [LANES-1:0] tx2;
   } link_state_t;

endpackage : loopback_mgmt_pkg

// [design/loopback_mgmt.sv]
// management slave, status indicator and lane loopback of the loopback module
module loopback_mgmt #(
   parameter logic [7:0] FORM_ID = 8'h5A,          // arbitrary identification value
   parameter logic MAX20_BIT = 1'b0,
   parameter logic [3:0] MAX_PWR_ID = 4'h0,
   parameter int BLINK_HALF_CYC = loopback_mgmt_pkg::BLINK_HALF_CYC_DEF,
   parameter int MAX_STRETCH_CYC = loopback_mgmt_pkg::MAX_STRETCH_CYC_DEF,
   parameter logic [loopback_mgmt_pkg::STR_W-1:0] STRETCH_CYC =
      loopback_mgmt_pkg::STRETCH_CYC_DEF
) (
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic LINK_CLK,
   input wire logic SCL_IN,
   output logic SCL_OUT,
   output logic SCL_OE,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic MODULE_SELECT_N,
   input wire logic LOW_POWER_PIN,
   input wire logic [7:0] ALARM_IN,
   output logic INTERRUPT_REQUEST_N,
   output logic POWER_HIGH,
   output loopback_mgmt_pkg::led_t LED,
   input wire logic [loopback_mgmt_pkg::LANES-1:0] TX_LANE,
   output logic [loopback_mgmt_pkg::LANES-1:0] RX_LANE
);
   import loopback_mgmt_pkg::*;

   localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_HALF_CYC - 1);

   sys_state_t s_r;
   sys_state_t s_nxt;
   link_state_t l_r;
   link_state_t l_nxt;

   logic scl;
   logic scl_q;
   logic sda;
   logic sda_q;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic selected;
   logic clr_flags;
   logic [7:0] ld_byte;
   logic [7:0] ptr_inc;

   // ----------------------------------------------------------------
   // read map
   // ----------------------------------------------------------------
   function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] fl,
                                          input logic [2:0] pc);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         FORM_ID_ADDR: v = FORM_ID;
         MOD_STATE_ADDR: v = MOD_STATE_VAL;
         FLAG_ADDR: v = fl;
         TYPE_ADDR: v = TYPE_VAL;
         HOST_IF_ADDR: v = HOST_IF_VAL;
         MEDIA_IF_ADDR: v = MEDIA_IF_VAL;
         LANE_CNT_ADDR: v = LANE_CNT_VAL;
         PWR_CLASS_ADDR: v = {pc, MAX20_BIT, MAX_PWR_ID};
         default: v = 8'h00;
      endcase
      return v;
   endfunction : rd_byte

   function automatic logic low_power(input logic [2:0] pc, input logic pin);
      return ({pc, MAX20_BIT} == 4'h0) || pin;
   endfunction : low_power

   // ----------------------------------------------------------------
   // pin sampling and bus events
   // ----------------------------------------------------------------
   // edges are taken between the second and third flop, never the first
   assign scl = s_r.scl_s[1];
   assign scl_q = s_r.scl_s[2];
   assign sda = s_r.sda_s[1];
   assign sda_q = s_r.sda_s[2];
   assign rise = scl && !scl_q;
   assign fall = !scl && scl_q;
   assign start = scl && scl_q && sda_q && !sda;
   assign stop = scl && scl_q && !sda_q && sda;
   assign selected = !s_r.sel_s[1];
   assign ptr_inc = s_r.ptr + 8'h01;

   // ----------------------------------------------------------------
   // system domain next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      clr_flags = 1'b0;
      ld_byte = 8'h00;
      s_nxt.scl_s = {s_r.scl_s[1], s_r.scl_s[0], SCL_IN};
      s_nxt.sda_s = {s_r.sda_s[1], s_r.sda_s[0], SDA_IN};
      s_nxt.sel_s = {s_r.sel_s[0], MODULE_SELECT_N};
      s_nxt.lp_s = {s_r.lp_s[0], LOW_POWER_PIN};
      s_nxt.al_s1 = ALARM_IN;
      s_nxt.al_s2 = s_r.al_s1;
      if (s_r.str_cnt != '0) begin
         s_nxt.str_cnt = s_r.str_cnt - 1'b1;
      end
      // sampling at 100 MHz leaves wide margin on any scl rate up to 400 kHz
      if (start && selected) begin
         s_nxt.st = ST_ADDR;
         s_nxt.cnt = 4'h0;
         s_nxt.sda_oe = 1'b0;
      end else if (stop || !selected) begin
         s_nxt.st = ST_IDLE;
         s_nxt.sda_oe = 1'b0;
         s_nxt.str_cnt = '0;
      end else begin
         case (s_r.st)
            ST_IDLE: begin
               s_nxt.sda_oe = 1'b0;
            end
            ST_ADDR: begin
               if (rise) begin
                  s_nxt.sh = {s_r.sh[6:0], sda};
                  s_nxt.cnt = s_r.cnt + 4'h1;
               end else if (fall && s_r.cnt == BYTE_BITS) begin
                  if (s_r.sh[7:1] == DEV_ADDR) begin
                     s_nxt.st = ST_ACK_A;
                     s_nxt.sda_oe = 1'b1;
                  end else begin
                     s_nxt.st = ST_IDLE;
                  end
               end
            end
            ST_ACK_A: begin
               if (fall) begin
                  s_nxt.cnt = 4'h0;
                  if (s_r.sh[0]) begin
                     ld_byte = rd_byte(s_r.ptr, s_r.flags, s_r.pcls);
                     clr_flags = (s_r.ptr == FLAG_ADDR);
                     s_nxt.st = ST_RD;
                     s_nxt.sh = ld_byte;
                     s_nxt.sda_oe = !ld_byte[7];
                  end else begin
                     s_nxt.st = ST_WR;
                     s_nxt.sda_oe = 1'b0;
                     s_nxt.ptr_ok = 1'b0;
                  end
               end
            end
            ST_WR: begin
               if (rise) begin
                  s_nxt.sh = {s_r.sh[6:0], sda};
                  s_nxt.cnt = s_r.cnt + 4'h1;
               end else if (fall && s_r.cnt == BYTE_BITS) begin
                  s_nxt.st = ST_ACK_W;
                  s_nxt.sda_oe = 1'b1;
                  if (!s_r.ptr_ok) begin
                     s_nxt.ptr = s_r.sh;
                     s_nxt.ptr_ok = 1'b1;
                  end else begin
                     if (s_r.ptr == PWR_CLASS_ADDR) begin
                        s_nxt.pcls = s_r.sh[7:PCLS_LSB];
                     end
                     s_nxt.ptr = ptr_inc;
                  end
               end
            end
            ST_ACK_W: begin
               if (fall) begin
                  s_nxt.st = ST_WR;
                  s_nxt.cnt = 4'h0;
                  s_nxt.sda_oe = 1'b0;
               end
            end
            ST_RD: begin
               if (rise) begin
                  s_nxt.cnt = s_r.cnt + 4'h1;
               end else if (fall) begin
                  if (s_r.cnt == BYTE_BITS) begin
                     s_nxt.st = ST_ACK_R;
                     s_nxt.sda_oe = 1'b0;
                  end else begin
                     s_nxt.sh = {s_r.sh[6:0], 1'b0};
                     s_nxt.sda_oe = !s_r.sh[6];
                  end
               end
            end
            ST_ACK_R: begin
               if (rise) begin
                  s_nxt.nack = sda;
               end else if (fall) begin
                  if (s_r.nack) begin
                     s_nxt.st = ST_IDLE;
                  end else begin
                     ld_byte = rd_byte(ptr_inc, s_r.flags, s_r.pcls);
                     clr_flags = (ptr_inc == FLAG_ADDR);
                     s_nxt.ptr = ptr_inc;
                     s_nxt.st = ST_RD;
                     s_nxt.cnt = 4'h0;
                     s_nxt.sh = ld_byte;
                     s_nxt.sda_oe = !ld_byte[7];
                     // short hold while the next byte settles, far under the limit
                     s_nxt.str_cnt = STRETCH_CYC;
                  end
               end
            end
            default: begin
               s_nxt.st = ST_IDLE;
               s_nxt.sda_oe = 1'b0;
            end
         endcase
      end
      // a new alarm in the clearing cycle survives the clear
      s_nxt.flags = (clr_flags ? 8'h00 : s_r.flags) | s_r.al_s2;
      s_nxt.int_n = !(|s_nxt.flags);
      if (s_r.blink_cnt == BLINK_LAST) begin
         s_nxt.blink_cnt = '0;
         s_nxt.blink = !s_r.blink;
      end else begin
         s_nxt.blink_cnt = s_r.blink_cnt + 1'b1;
      end
      s_nxt.pwr_hi = !low_power(s_nxt.pcls, s_nxt.lp_s[1]);
      // solid while no flag, blinking otherwise
      s_nxt.led.green = !s_nxt.pwr_hi && (s_nxt.int_n || s_nxt.blink);
      s_nxt.led.red = s_nxt.pwr_hi && (s_nxt.int_n || s_nxt.blink);
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
         s_r.scl_s <= 3'h7;
         s_r.sda_s <= 3'h7;
         s_r.sel_s <= 2'h3;
         s_r.pcls <= PCLS_RESET;
         s_r.int_n <= 1'b1;
         // power class zero means low power, so the indicator is solid green in reset
         s_r.led.green <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----------------------------------------------------------------
   // link domain loopback
   // ----------------------------------------------------------------
   // reset level crosses by two flops; lanes pass a two-flop sampler
   always_comb begin
      l_nxt = l_r;
      l_nxt.rst_s = {l_r.rst_s[0], SYS_RST};
      if (l_r.rst_s[1]) begin
         l_nxt.tx1 = '0;
         l_nxt.tx2 = '0;
      end else begin
         l_nxt.tx1 = TX_LANE;
         l_nxt.tx2 = l_r.tx1;
      end
   end

   always_ff @(posedge LINK_CLK) begin
      l_r <= l_nxt;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign SCL_OUT = 1'b0;
   assign SCL_OE = (s_r.str_cnt != '0);
   assign SDA_OUT = 1'b0;
   assign SDA_OE = s_r.sda_oe;
   assign INTERRUPT_REQUEST_N = s_r.int_n;
   assign POWER_HIGH = s_r.pwr_hi;
   assign LED = s_r.led;
   assign RX_LANE = l_r.tx2;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);

   a_power_class_low: assert property (
      $past(s_nxt.pcls == 3'h0 && !MAX20_BIT) |-> !POWER_HIGH)
      else $error("power class zero did not give low power");
   a_pin_forces_low: assert property (
      s_r.lp_s[1] |-> !POWER_HIGH)
      else $error("low-power pin high but high power shown");
   a_solid_colour: assert property (
      INTERRUPT_REQUEST_N |-> (LED.green == !POWER_HIGH) && (LED.red == POWER_HIGH))
      else $error("solid indicator colour wrong");
   a_blink_colour: assert property (
      !INTERRUPT_REQUEST_N |-> !(POWER_HIGH ? LED.green : LED.red)
         && ((LED.green || LED.red) == s_r.blink))
      else $error("blinking indicator wrong");
   a_blink_period: assert property (
      $changed(s_r.blink) |-> $past(s_r.blink_cnt) == BLINK_LAST)
      else $error("blink toggled off period");
   a_stretch_short: assert property (
      $rose(SCL_OE) |-> ##[1:300] !SCL_OE)
      else $error("clock stretch too long");
   a_stretch_limit: assert property (
      SCL_OE |-> (int'(s_r.str_cnt) < MAX_STRETCH_CYC))
      else $error("stretch count over limit");
   a_alarm_interrupt: assert property (
      (|s_r.al_s2) |=> !INTERRUPT_REQUEST_N && (s_r.flags & $past(s_r.al_s2)) != 8'h00)
      else $error("alarm did not raise interrupt");
   a_address_ack: assert property (
      (s_r.st == ST_ACK_A) |-> SDA_OE)
      else $error("address not acknowledged");
   a_read_load: assert property (
      ($rose(s_r.st == ST_RD) && s_r.ptr != FLAG_ADDR)
         |-> s_r.sh == rd_byte(s_r.ptr, s_r.flags, s_r.pcls))
      else $error("read byte does not match map");
   a_lane_loop: assert property (@(posedge LINK_CLK)
      disable iff (l_r.rst_s[1])
      $past(!l_r.rst_s[1], 2) |-> RX_LANE == $past(TX_LANE, 2))
      else $error("receive lane differs from transmit lane");

   c_read_done: cover property ((s_r.st == ST_ACK_R) ##1 (s_r.st == ST_RD));
   c_pclass_write: cover property ($changed(s_r.pcls));
   c_blink_int: cover property (!INTERRUPT_REQUEST_N && $changed(s_r.blink));
   c_stretch: cover property ($rose(SCL_OE));

endmodule : loopback_mgmt

// [verification/twi_host_model.sv]
// two-wire host master model: open-drain pulls and register transfers
module twi_host_model #(
   parameter int Q = 63
) (
   input wire logic clk,
   input wire logic scl,
   input wire logic sda,
   output logic scl_low,
   output logic sda_low
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [7:0] rbuf [8];
   logic all_ack;

   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
      all_ack = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   // release the clock, then wait out any stretch by the device, bounded
   task automatic scl_rise();
      int w;
      scl_low = 1'b0;
      w = 0;
      tick(1);
      while (scl !== 1'b1 && w < 20000) begin
         tick(1);
         w++;
      end
   endtask : scl_rise

   // a quarter of the bit time is 63 cycles, just under 400 kHz
   task automatic bit_xfer(input logic b, output logic s);
      sda_low = ~b;
      tick(Q);
      scl_rise();
      tick(Q);
      s = sda;
      tick(Q);
      scl_low = 1'b1;
      tick(Q);
   endtask : bit_xfer

   task automatic start();
      sda_low = 1'b0;
      tick(Q);
      scl_rise();
      tick(Q);
      sda_low = 1'b1;
      tick(Q);
      scl_low = 1'b1;
      tick(Q);
   endtask : start

   task automatic stop();
      sda_low = 1'b1;
      tick(Q);
      scl_rise();
      tick(Q);
      sda_low = 1'b0;
      tick(Q);
   endtask : stop

   task automatic byte_out(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
      bit_xfer(1'b1, s);
      if (s !== 1'b0) all_ack = 1'b0;
   endtask : byte_out

   // last byte gets no acknowledge so the device lets go of the data line
   task automatic byte_in(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, s);
         d[i] = s;
      end
      bit_xfer(last, s);
   endtask : byte_in

   task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
      all_ack = 1'b1;
      start();
      byte_out(8'hA0);
      byte_out(p);
      byte_out(d);
      stop();
   endtask : write_reg

   task automatic read_regs(input logic [7:0] p, input int n);
      all_ack = 1'b1;
      start();
      byte_out(8'hA0);
      byte_out(p);
      start();
      byte_out(8'hA1);
      for (int i = 0; i < n; i++) byte_in(i == n - 1, rbuf[i]);
      stop();
   endtask : read_regs
endmodule : twi_host_model

// [verification/testbench.sv]
// self-checking bench for the loopback module management block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import loopback_mgmt_pkg::*;

   localparam logic [7:0] ID_VAL = 8'h5A; // arbitrary identification value
   localparam int LIMIT = 100000;
   logic sys_clk = 1'b0;
   logic link_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic lp_pin = 1'b0;
   logic sel_n = 1'b0;
   logic [7:0] alarm = 8'h00;
   logic [LANES-1:0] tx = '0;
   logic scl_oe, scl_o, sda_oe, sda_o, int_n, pwr_hi, m_scl, m_sda;
   logic [LANES-1:0] rx;
   led_t led;
   wire scl_w;
   wire sda_w;
   int n_mismatch = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [7:0] exp_map[int];
   logic [7:0] q[$];

   // both lines have pull-ups: released means high
   assign scl_w = ~(m_scl | scl_oe);
   assign sda_w = ~(m_sda | sda_oe);

   always #5 sys_clk = ~sys_clk;
   initial begin
      #3.3;
      forever #40 link_clk = ~link_clk;
   end

   loopback_mgmt #(.FORM_ID(ID_VAL), .BLINK_HALF_CYC(8)) DUT (
      .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LINK_CLK(link_clk),
      .SCL_IN(scl_w), .SCL_OUT(scl_o), .SCL_OE(scl_oe),
      .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE(sda_oe),
      .MODULE_SELECT_N(sel_n), .LOW_POWER_PIN(lp_pin), .ALARM_IN(alarm),
      .INTERRUPT_REQUEST_N(int_n), .POWER_HIGH(pwr_hi), .LED(led),
      .TX_LANE(tx), .RX_LANE(rx)
   );

   twi_host_model host (
      .clk(sys_clk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda)
   );

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         close_out();
      end
   end

   // solid colour: green in low power, red in high power
   task automatic check_solid(input logic hi);
      check("power_high", {7'h00, pwr_hi}, {7'h00, hi});
      check("led", {6'h00, led}, {6'h00, ~hi, hi});
   endtask : check_solid

   initial begin
      int on_n, off_n, other_n;
      logic [2:0] pc;
      logic [7:0] val;
      void'($urandom(93496));
      exp_map = '{0: ID_VAL, 1: 8'h00, 2: 8'h00, 3: MOD_STATE_VAL, 85: TYPE_VAL,
                  86: 8'h11, 87: 8'hBF, 88: 8'h80};
      // twenty cycles span two link edges, enough for its two-flop reset
      repeat (20) @(posedge sys_clk);
      #1;
      sys_rst = 1'b0;
      host.tick(3);
      check("int_n", {7'h00, int_n}, 8'h01);
      check_solid(1'b0);
      check("scl_sda_out", {6'h00, scl_o, sda_o}, 8'h00);
      // ---------------------------------------------
      // identification bytes
      // ---------------------------------------------
      host.read_regs(8'h00, 4);
      check("ack", {7'h00, host.all_ack}, 8'h01);
      check("form_id", host.rbuf[0], exp_map[0]);
      check("gap1", host.rbuf[1], exp_map[1]);
      check("gap2", host.rbuf[2], exp_map[2]);
      check("mod_state", host.rbuf[3] & 8'hFE, exp_map[3]);
      host.read_regs(TYPE_ADDR, 4);
      check("type", host.rbuf[0], exp_map[85]);
      check("host_if", host.rbuf[1], exp_map[86]);
      check("media_if", host.rbuf[2], exp_map[87]);
      check("lanes", host.rbuf[3], exp_map[88]);
      // ---------------------------------------------
      // power class and module select
      // ---------------------------------------------
      pc = 3'($urandom_range(1, 7));
      host.write_reg(PWR_CLASS_ADDR, {pc, 5'h1F});
      check("wr_ack", {7'h00, host.all_ack}, 8'h01);
      host.tick(5);
      check_solid(1'b1);
      host.read_regs(PWR_CLASS_ADDR, 1);
      check("pwr_class", host.rbuf[0], {pc, 5'h00});
      // deselected: no acknowledge, and the power class keeps its value
      sel_n = 1'b1;
      host.tick(5);
      host.write_reg(PWR_CLASS_ADDR, 8'h00);
      check("desel_ack", {7'h00, host.all_ack}, 8'h00);
      sel_n = 1'b0;
      host.tick(5);
      check_solid(1'b1);
      // ---------------------------------------------
      // interrupt blink in each power mode
      // ---------------------------------------------
      for (int m = 0; m < 2; m++) begin
         lp_pin = (m == 0);
         host.tick(5);
         check_solid(m[0]);
         val = 8'($urandom_range(1, 255));
         alarm = val;
         host.tick(5);
         alarm = 8'h00;
         on_n = 0;
         off_n = 0;
         other_n = 0;
         repeat (40) begin
            host.tick(1);
            if (int_n !== 1'b0) other_n++;
            if ((m == 1 ? led.red : led.green) === 1'b1) on_n++;
            else off_n++;
            if ((m == 1 ? led.green : led.red) !== 1'b0) other_n++;
         end
         check("blink_on", {7'h00, on_n > 0}, 8'h01);
         check("blink_off", {7'h00, off_n > 0}, 8'h01);
         check("blink_other", 8'(other_n), 8'h00);
         host.read_regs(FLAG_ADDR, 1);
         check("flags", host.rbuf[0], val);
         host.tick(5);
         check("int_clr", {7'h00, int_n}, 8'h01);
         check_solid(m[0]);
      end
      // ---------------------------------------------
      // lane loopback in the link domain
      // ---------------------------------------------
      repeat (24) begin
         @(posedge link_clk);
         #1;
         if (q.size() == 2) check("rx_lane", rx, q.pop_front());
         tx = LANES'($urandom);
         q.push_back(tx);
      end
      close_out();
   end
endmodule : testbench
